/* File: rtl/mfs_cfg.svh */
/*
 * constants for the motor fault supervisor: timing counts and thresholds.
 * assumes a 100 MHz clock and currents scaled so rated current = 3200.
 */
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH

// ------------------------------------------------------------------
// timebase
// ------------------------------------------------------------------
`define MFS_CLK_HZ          100000000
`define MFS_TICK_MS         100
`define MFS_TICK_CYCLES     ((`MFS_CLK_HZ / 1000) * `MFS_TICK_MS)
`define MFS_TICKS_PER_S     (1000 / `MFS_TICK_MS)

// ------------------------------------------------------------------
// times in their own units
// ------------------------------------------------------------------
`define MFS_RESID_SUPP_S    1
`define MFS_RUN_BLOCK_S     1
`define MFS_RECOV_MIN_S     60
`define MFS_RECOV_MAX_S     1800

// ------------------------------------------------------------------
// currents: 3200 counts = 100% of rated current
// ------------------------------------------------------------------
`define MFS_CUR_W           16
`define MFS_RATED_SCALE     3200
`define MFS_RESID_PCT_X100  1875
`define MFS_RUN_BLOCK_PCT   400

`endif

/* File: rtl/mfs_pkg.sv */
/*
 * types shared by the motor fault supervisor files.
 * assumes nothing of its surroundings.
 */
package mfs_pkg;
	typedef enum logic [1:0] {SENS_OFF, SENS_SWITCH, SENS_THERMISTOR, SENS_RSVD} mfs_sens_t;
	typedef enum logic [1:0] {RESP_TRIP_HOLD, RESP_TRIP_AUTO, RESP_WARN, RESP_RSVD} mfs_resp_t;
	typedef enum logic [1:0] {ST_IDLE, ST_TRIPPED, ST_RECOVER} mfs_state_t;
endpackage : mfs_pkg

/* File: rtl/mfs_tick_gen.sv */
/*
 * slow timebase: one-cycle enable every TICK_CYCLES clocks.
 * assumes a synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "mfs_cfg.svh"

module mfs_tick_gen
#(
	parameter int TICK_CYCLES = `MFS_TICK_CYCLES
)
(
	input  wire logic clock,
	input  wire logic rst,
	output logic      tick
);
	typedef struct packed {
		logic [23:0] cnt;
		logic        tick;
	} mfs_tick_st_t;

	mfs_tick_st_t st_reg;
	mfs_tick_st_t st_next;

	// ------------------------------------------------------------------
	// divider
	// ------------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt >= 24'(TICK_CYCLES - 1))
		begin
			st_next.cnt = 24'h000000;
			st_next.tick = 1'b1;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + 24'h000001;
		end
	end

	// registered copy
	always_ff @(posedge clock)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick = st_reg.tick;
endmodule : mfs_tick_gen

/* File: rtl/mfs_supervisor.sv */
/*
 * motor fault supervisor: winding sensor, cable check, current limits,
 * residual current and blocking protection, sticky trip and trip counter.
 * assumes sensor status pins are asynchronous and current words are
 * steady values from logic on this clock, scaled 3200 = rated current.
 * also assumes settings are held steady while the motor runs.
 */
`timescale 1ns/10ps
`include "mfs_cfg.svh"

module mfs_supervisor
	import mfs_pkg::*;
#(
	parameter int TICK_CYCLES = `MFS_TICK_CYCLES,
	parameter int CW          = `MFS_CUR_W
)
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              sensorOverPin,
	input  wire logic              sensorBreakPin,
	input  wire logic              sensorShortPin,
	input  wire logic [CW-1:0]     phaseCurA,
	input  wire logic [CW-1:0]     phaseCurB,
	input  wire logic [CW-1:0]     phaseCurC,
	input  wire logic              startCmd,
	input  wire logic              tripResetCmd,
	input  wire mfs_pkg::mfs_sens_t sensorType,
	input  wire mfs_pkg::mfs_resp_t sensorResp,
	input  wire logic              cableTripEn,
	input  wire logic              residTripEn,
	input  wire logic              limitTripEn,
	input  wire logic [CW-1:0]     upperLimit,
	input  wire logic [CW-1:0]     lowerLimit,
	input  wire logic [CW-1:0]     blockCurrent,
	input  wire logic [7:0]        blockTimeTicks,
	input  wire logic [15:0]       classTimeTicks,
	input  wire logic [10:0]       recoverySec,
	output logic                   motorDrive,
	output logic                   tripOut,
	output logic                   sensorOverMsg,
	output logic                   wireBreakMsg,
	output logic                   shortCircMsg,
	output logic                   overloadTripMsg,
	output logic                   sensorOffMsg,
	output logic                   residWarnMsg,
	output logic                   residTripMsg,
	output logic                   upperViolMsg,
	output logic                   lowerViolMsg,
	output logic                   limitTripMsg,
	output logic                   blockTripMsg,
	output logic                   groupFaultMsg,
	output logic                   coolingMsg,
	output logic [15:0]            overloadTripCount
);
	import mfs_pkg::*;

	// ------------------------------------------------------------------
	// thresholds and fixed times
	// ------------------------------------------------------------------
	// every current shares one scale, so percentages become plain counts;
	// rounding down keeps the residual threshold on the safe side
	// fixed times are in ticks, the only rate that the timers see, except the recovery bounds, which are in seconds
	localparam logic [CW-1:0] RESID_THR =
		CW'((`MFS_RATED_SCALE * `MFS_RESID_PCT_X100) / 10000);
	localparam logic [CW-1:0] RUN_BLOCK_CAP =
		CW'((`MFS_RATED_SCALE * `MFS_RUN_BLOCK_PCT) / 100);
	localparam logic [7:0] RUN_BLOCK_TICKS = 8'(`MFS_RUN_BLOCK_S * `MFS_TICKS_PER_S);
	localparam logic [7:0] RESID_SUPP_TICKS = 8'(`MFS_RESID_SUPP_S * `MFS_TICKS_PER_S);
	localparam logic [10:0] RECOV_MIN = 11'(`MFS_RECOV_MIN_S);
	localparam logic [10:0] RECOV_MAX = 11'(`MFS_RECOV_MAX_S);
	localparam logic [3:0] TPS = 4'(`MFS_TICKS_PER_S);

	// clamp a recovery setting into its legal range; a bad word is pulled
	// in rather than refused, so cooling can never be switched off
	// by a zero setting
	function automatic logic [10:0] clampRecov(input logic [10:0] v);
		if (v < RECOV_MIN)
			return RECOV_MIN;
		else if (v > RECOV_MAX)
			return RECOV_MAX;
		else
			return v;
	endfunction : clampRecov

	// true when a count has reached a limit, saturating counters
	// compare with >= so a limit lowered mid-run still takes effect
	function automatic logic reached(input logic [15:0] cnt, input logic [15:0] lim);
		return cnt >= lim;
	endfunction : reached

	// ------------------------------------------------------------------
	// state record
	// ------------------------------------------------------------------
	// syncA, syncB: two flops per sensor pin, in short-break-over order
	// auto: the trip may clear by restart, only for a sensor-only trip
	// src fields: latched trip causes, they drive the trip messages
	// running: registered drive, also the switch-on reference
	// onTicks: ticks since switch-on, gates residual and limit checks
	// recovSec, subTicks: cooling countdown in seconds and ticks
	// tripCount, groupFault: bookkeeping of blocking after run-up
	typedef struct packed {
		logic [2:0]  syncA;
		logic [2:0]  syncB;
		mfs_state_t  state;
		logic        auto;
		logic        srcSensor;
		logic        srcCable;
		logic        srcResid;
		logic        srcLimit;
		logic        srcBlock;
		logic        running;
		logic [15:0] onTicks;
		logic [7:0]  blockTicks;
		logic [10:0] recovSec;
		logic [3:0]  subTicks;
		logic [15:0] tripCount;
		logic        groupFault;
	} mfs_state_st_t;

	mfs_state_st_t st_reg;
	mfs_state_st_t st_next;

	logic tick;

	// ------------------------------------------------------------------
	// timebase
	// ------------------------------------------------------------------
	// one divider feeds every timer, so all of them step together;
	// the price is a resolution of one tick on every time
	mfs_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clock (clock),
		.rst   (rst),
		.tick  (tick)
	);

	// ------------------------------------------------------------------
	// condition decode
	// ------------------------------------------------------------------
	// conditions are plain levels; the state machine latches the cause,
	// so a condition that lasts one cycle in idle still trips
	logic sensOn;
	logic cableOn;
	logic sensOver;
	logic wireBrk;
	logic shortCk;
	logic residNow;
	logic upperNow;
	logic lowerNow;
	logic runUp;
	logic [CW-1:0] blkThr;
	logic [7:0]    blkTime;
	logic blkNow;
	logic anyCond;

	// second sync stage is the only reader of the first
	// sensor pins are asynchronous, so only the second stage is decoded
	assign sensOn  = (sensorType == SENS_SWITCH) || (sensorType == SENS_THERMISTOR);
	assign cableOn = (sensorType == SENS_THERMISTOR);
	assign sensOver = sensOn && st_reg.syncB[0];
	assign wireBrk  = cableOn && st_reg.syncB[1];
	assign shortCk  = cableOn && st_reg.syncB[2];
	// residual needs every phase low and the switch-on window passed
	// the window counts from the rise of the drive, not from the command
	assign residNow = st_reg.running && (st_reg.onTicks >= 16'(RESID_SUPP_TICKS))
		&& (phaseCurA < RESID_THR) && (phaseCurB < RESID_THR)
		&& (phaseCurC < RESID_THR);
	assign runUp    = st_reg.running && reached(st_reg.onTicks, classTimeTicks);
	// a zero limit deactivates that side
	// each side looks at every phase, so one bad phase is enough
	assign upperNow = runUp && (upperLimit != '0) && ((phaseCurA > upperLimit)
		|| (phaseCurB > upperLimit) || (phaseCurC > upperLimit));
	assign lowerNow = runUp && (lowerLimit != '0) && ((phaseCurA < lowerLimit)
		|| (phaseCurB < lowerLimit) || (phaseCurC < lowerLimit));
	// the cap applies only after run-up, so a heavy start keeps its setting
	assign blkThr  = (runUp && (blockCurrent > RUN_BLOCK_CAP)) ? RUN_BLOCK_CAP
		: blockCurrent;
	// in continuous operation a stall is cut after the fixed short time
	assign blkTime = runUp ? RUN_BLOCK_TICKS : blockTimeTicks;
	assign blkNow  = st_reg.running && ((phaseCurA > blkThr) || (phaseCurB > blkThr)
		|| (phaseCurC > blkThr));
	// pending sensor-line conditions hold off a manual trip reset
	assign anyCond = sensOver || wireBrk || shortCk;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		// pins shift into the synchroniser every clock
		st_next.syncA = {sensorShortPin, sensorBreakPin, sensorOverPin};
		st_next.syncB = st_reg.syncA;
		st_next.running = startCmd && (st_reg.state == ST_IDLE);
		// on-time counts from switch-on, saturating
		// so a long run never looks like a fresh start
		if (!st_next.running)
			st_next.onTicks = 16'h0000;
		else if (tick && (st_reg.onTicks != 16'hFFFF))
			st_next.onTicks = st_reg.onTicks + 16'h0001;
		// blocking timer runs only while above threshold; one cycle below
		// restarts it, so a current that dips keeps the trip away
		if (!blkNow)
			st_next.blockTicks = 8'h00;
		else if (tick && (st_reg.blockTicks != 8'hFF))
			st_next.blockTicks = st_reg.blockTicks + 8'h01;
		// causes are sampled only in idle: the record shows what was seen
		// on the trip edge, and later causes do not change it
		case (st_reg.state)
			ST_IDLE:
			begin
				st_next.srcSensor = sensOver && (sensorResp != RESP_WARN);
				st_next.srcCable  = (wireBrk || shortCk) && cableTripEn;
				st_next.srcResid  = residNow && residTripEn;
				st_next.srcLimit  = (upperNow || lowerNow) && limitTripEn;
				st_next.srcBlock  = blkNow && (st_reg.blockTicks >= blkTime);
				// any other cause next to the sensor needs a manual reset
				st_next.auto = st_next.srcSensor && (sensorResp == RESP_TRIP_AUTO)
					&& !st_next.srcCable && !st_next.srcResid && !st_next.srcLimit
					&& !st_next.srcBlock;
				if (st_next.srcSensor || st_next.srcCable || st_next.srcResid
					|| st_next.srcLimit || st_next.srcBlock)
				begin
					st_next.state = ST_RECOVER;
					st_next.recovSec = clampRecov(recoverySec);
					st_next.subTicks = 4'h0;
					st_next.running = 1'b0;
					if (st_next.srcBlock && runUp)
					begin
						st_next.groupFault = 1'b1;
						st_next.tripCount = st_reg.tripCount + 16'h0001;
					end
				end
			end
			ST_RECOVER:
			begin
				// reset requests have no effect here
				// the countdown runs even while the cause is still present
				if (tick)
				begin
					if (st_reg.subTicks == TPS - 4'h1)
					begin
						st_next.subTicks = 4'h0;
						if (st_reg.recovSec != 11'h000)
							st_next.recovSec = st_reg.recovSec - 11'h001;
					end
					else
						st_next.subTicks = st_reg.subTicks + 4'h1;
				end
				// wait one more tick after the count ends: the first tick
				// comes early, and the cooling must never run short
				if ((st_reg.recovSec == 11'h000) && tick)
					st_next.state = ST_TRIPPED;
			end
			ST_TRIPPED:
			begin
				if (st_reg.auto)
				begin
					// auto restart only with sensor clear and start asked
					// a start command held through the trip restarts at once
					if (!sensOver && startCmd)
						st_next.state = ST_IDLE;
				end
				else if (tripResetCmd && !anyCond && !residNow)
					st_next.state = ST_IDLE;
				// leaving the trip drops every cause and trip message at once
				if (st_next.state == ST_IDLE)
				begin
					st_next.srcSensor = 1'b0;
					st_next.srcCable = 1'b0;
					st_next.srcResid = 1'b0;
					st_next.srcLimit = 1'b0;
					st_next.srcBlock = 1'b0;
					st_next.groupFault = 1'b0;
					st_next.auto = 1'b0;
				end
			end
			// unused state code: fall back to idle and let the inputs decide
			default:
			begin
				st_next.state = ST_IDLE;
			end
		endcase
	end

	// registered copy, the only clocked process of the block besides the tick divider
	// reset clears causes, the trip counter and every timer
	always_ff @(posedge clock)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// warnings and live messages follow their conditions and clear on
	// their own; trip messages show the latched cause until cleared
	// limitation: the group fault stands for any trip, not blocking only
	assign motorDrive      = st_reg.running;
	assign tripOut         = (st_reg.state != ST_IDLE);
	assign sensorOverMsg   = sensOver;
	assign wireBreakMsg    = wireBrk;
	assign shortCircMsg    = shortCk;
	assign overloadTripMsg = st_reg.srcSensor || st_reg.srcCable;
	assign sensorOffMsg    = !sensOn;
	assign residWarnMsg    = residNow && !residTripEn;
	assign residTripMsg    = st_reg.srcResid;
	assign upperViolMsg    = upperNow;
	assign lowerViolMsg    = lowerNow;
	assign limitTripMsg    = st_reg.srcLimit;
	assign blockTripMsg    = st_reg.srcBlock;
	assign groupFaultMsg   = st_reg.groupFault || (st_reg.state != ST_IDLE);
	assign coolingMsg      = (st_reg.state == ST_RECOVER);
	assign overloadTripCount = st_reg.tripCount;
endmodule : mfs_supervisor

/* File: dv/mfs_sup_asserts.sv */
/*
 * port checker for the supervisor: trip, message and counter relations.
 * assumes it is bound into mfs_supervisor and sees its ports only.
 */
`timescale 1ns/10ps
module mfs_sup_asserts
(
	input wire logic               clock,
	input wire logic               rst,
	input wire logic               sensorOverPin,
	input wire logic               tripResetCmd,
	input wire mfs_pkg::mfs_sens_t sensorType,
	input wire mfs_pkg::mfs_resp_t sensorResp,
	input wire logic               motorDrive,
	input wire logic               tripOut,
	input wire logic               sensorOverMsg,
	input wire logic               wireBreakMsg,
	input wire logic               shortCircMsg,
	input wire logic               sensorOffMsg,
	input wire logic               residWarnMsg,
	input wire logic               blockTripMsg,
	input wire logic               groupFaultMsg,
	input wire logic               coolingMsg,
	input wire logic [15:0]        overloadTripCount
);
	import mfs_pkg::*;
	default clocking dc @(posedge clock); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	// a trip must take the drive away one clock later
	trip_cuts_a: assert property (tripOut |=> !motorDrive)
		else $error("drive on while tripped");
	off_quiet_a: assert property
		(sensorOffMsg |-> !(sensorOverMsg || wireBreakMsg || shortCircMsg))
		else $error("sensor message while sensor off");
	sw_nocable_a: assert property
		(sensorType == SENS_SWITCH |-> !wireBreakMsg && !shortCircMsg)
		else $error("cable message with switch sensor");
	// five clocks covers the two-flop sync plus the trip edge
	pin_trip_a: assert property
		((sensorOverPin && sensorType == SENS_SWITCH && sensorResp == RESP_TRIP_HOLD) [*5]
		|=> tripOut)
		else $error("no trip on hot winding");
	count_step_a: assert property
		($changed(overloadTripCount) |-> overloadTripCount == $past(overloadTripCount) + 16'h0001)
		else $error("trip counter jumped");
	block_group_a: assert property (blockTripMsg |-> groupFaultMsg && tripOut)
		else $error("blocking trip without group fault");
	reset_refused_a: assert property (coolingMsg && tripResetCmd |=> tripOut)
		else $error("reset taken while cooling");
	resid_quiet_a: assert property ($rose(motorDrive) |=> (!residWarnMsg) [*8])
		else $error("residual warning right after switch on");
	// main scenarios reached
	cover property ($rose(blockTripMsg));
	cover property ($rose(residWarnMsg));
	cover property ($fell(coolingMsg));
endmodule : mfs_sup_asserts

/* File: dv/mfs_plant.sv */
/*
 * far-side model: winding sensor contacts and phase current measurement.
 * assumes the bench sets fault levels, load word and jitter.
 */
`timescale 1ns/10ps
module mfs_plant
(
	input  wire logic        clock,
	input  wire logic        motorDrive,
	input  wire logic        hot,
	input  wire logic        cut,
	input  wire logic        shorted,
	input  wire logic [15:0] load,
	input  wire logic [7:0]  jit,
	output logic             sensorOverPin,
	output logic             sensorBreakPin,
	output logic             sensorShortPin,
	output logic      [15:0] phaseCurA,
	output logic      [15:0] phaseCurB,
	output logic      [15:0] phaseCurC
);
	// ------------------------------------------------------------------
	// sensor line and current measurement
	// ------------------------------------------------------------------
	// contacts move off the clock grid, as a real sensor line does
	assign #3 sensorOverPin  = hot;
	assign #3 sensorBreakPin = cut;
	assign #3 sensorShortPin = shorted;
	// stopped motor draws nothing; jitter keeps the phases unequal
	always @(posedge clock)
	begin
		phaseCurA <= motorDrive ? load + {12'h000, jit[3:0]} : 16'h0000;
		phaseCurB <= motorDrive ? load + {12'h000, jit[7:4]} : 16'h0000;
		phaseCurC <= motorDrive ? load : 16'h0000;
	end
endmodule : mfs_plant

/* File: dv/tb.sv */
/*
 * top bench: sensor, cable, residual, limit and blocking cases with queued checks.
 * assumes a tick of 10 clocks, so one second is 100 clocks.
 */
`timescale 1ns/10ps
module tb;
	import mfs_pkg::*;
	logic        clock, rst, startCmd, tripResetCmd, cableTripEn, residTripEn;
	logic        limitTripEn, hot, cut, shorted;
	logic [15:0] upperLimit, lowerLimit, blockCurrent, classTimeTicks, load;
	logic [10:0] recoverySec;
	logic [7:0]  blockTimeTicks, jit;
	mfs_sens_t   sensorType;
	mfs_resp_t   sensorResp;
	wire         sensorOverPin, sensorBreakPin, sensorShortPin, motorDrive, tripOut;
	wire         sensorOverMsg, wireBreakMsg, shortCircMsg, overloadTripMsg, sensorOffMsg;
	wire         residWarnMsg, residTripMsg, upperViolMsg, lowerViolMsg, limitTripMsg;
	wire         blockTripMsg, groupFaultMsg, coolingMsg;
	wire  [15:0] phaseCurA, phaseCurB, phaseCurC, overloadTripCount;
	logic [63:0] notes[$];
	int          n_mismatch = 0;
	int          cmp_count = 0;
	event        look;
	// observed outputs, trip counter in the upper half
	wire  [31:0] obs = {overloadTripCount, upperViolMsg, lowerViolMsg, limitTripMsg, 1'b0,
		residWarnMsg, residTripMsg, blockTripMsg, groupFaultMsg, sensorOverMsg, wireBreakMsg,
		shortCircMsg, sensorOffMsg, motorDrive, tripOut, overloadTripMsg, coolingMsg};
	mfs_supervisor #(.TICK_CYCLES(10)) i_mfs_supervisor (.clock, .rst, .sensorOverPin,
		.sensorBreakPin, .sensorShortPin, .phaseCurA, .phaseCurB, .phaseCurC, .startCmd,
		.tripResetCmd, .sensorType, .sensorResp, .cableTripEn, .residTripEn, .limitTripEn,
		.upperLimit, .lowerLimit, .blockCurrent, .blockTimeTicks, .classTimeTicks,
		.recoverySec, .motorDrive, .tripOut, .sensorOverMsg, .wireBreakMsg, .shortCircMsg,
		.overloadTripMsg, .sensorOffMsg, .residWarnMsg, .residTripMsg, .upperViolMsg,
		.lowerViolMsg, .limitTripMsg, .blockTripMsg, .groupFaultMsg, .coolingMsg,
		.overloadTripCount);
	mfs_plant i_mfs_plant (.clock, .motorDrive, .hot, .cut, .shorted, .load, .jit,
		.sensorOverPin, .sensorBreakPin, .sensorShortPin, .phaseCurA, .phaseCurB, .phaseCurC);
	// ------------------------------------------------------------------
	// clock, jitter source, tasks
	// ------------------------------------------------------------------
	// free-running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// jitter stays under 16 counts so no threshold is crossed by chance
	always @(posedge clock)
		jit <= lfsr(jit);
	task go(input int n);
		repeat (n) @(posedge clock);
	endtask : go
	task chk(input logic [31:0] m, input logic [31:0] v);
		notes.push_back({m, v});
		-> look;
		// hold the stimulus one clock so the watcher sees settled outputs
		go(1);
	endtask : chk
	task cmp_out(input logic [31:0] m, input logic [31:0] v);
		cmp_count++;
		if (((obs ^ v) & m) !== 32'h0)
		begin
			n_mismatch++;
			$display("wrong value at %0t: obs %h want %h mask %h", $time, obs, v, m);
		end
	endtask : cmp_out
	task pulse_reset;
		tripResetCmd <= 1'b1;
		go(3);
		tripResetCmd <= 1'b0;
		go(4);
	endtask : pulse_reset
	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// watcher: oldest note against outputs settled after the edge
	initial
	forever
	begin
		@(look);
		#1;
		cmp_out(notes[0][63:32], notes[0][31:0]);
		void'(notes.pop_front());
	end
	// hang guard, well past the ~33k clocks the cases need
	initial
	begin
		#500000;
		n_mismatch++;
		wrap_up();
	end
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		{rst, startCmd} = 2'b11;
		{tripResetCmd, cableTripEn, residTripEn, limitTripEn, hot, cut, shorted} = 7'h00;
		{upperLimit, lowerLimit} = 32'h0;
		{blockCurrent, classTimeTicks, blockTimeTicks} = {16'h3E80, 16'h001E, 8'h14};
		{load, jit, recoverySec} = {16'h0C80, 8'h22, 11'h01E};
		sensorType = SENS_OFF;
		sensorResp = RESP_TRIP_HOLD;
		go(6);
		rst <= 1'b0;
		go(8);
		chk(32'h18, 32'h18);
		hot <= 1'b1;
		go(8);
		chk(32'h84, 32'h0);
		sensorType <= SENS_SWITCH;
		sensorResp <= RESP_WARN;
		go(8);
		chk(32'h8C, 32'h88);
		hot <= 1'b0;
		go(8);
		chk(32'h80, 32'h0);
		sensorResp <= RESP_TRIP_HOLD;
		hot <= 1'b1;
		go(8);
		chk(32'hF, 32'h7);
		hot <= 1'b0;
		pulse_reset();
		chk(32'h5, 32'h5);
		go(4000);
		chk(32'h1, 32'h1);
		go(2300);
		chk(32'h5, 32'h4);
		pulse_reset();
		chk(32'hC, 32'h8);
		sensorResp <= RESP_TRIP_AUTO;
		recoverySec <= 11'h03D;
		hot <= 1'b1;
		go(8);
		chk(32'h4, 32'h4);
		hot <= 1'b0;
		startCmd <= 1'b0;
		go(6300);
		chk(32'h4, 32'h4);
		startCmd <= 1'b1;
		go(4);
		chk(32'hC, 32'h8);
		cut <= 1'b1;
		go(8);
		chk(32'h44, 32'h0);
		sensorType <= SENS_THERMISTOR;
		go(8);
		chk(32'h4C, 32'h48);
		{cut, shorted, cableTripEn} <= 3'b011;
		go(8);
		chk(32'h26, 32'h26);
		shorted <= 1'b0;
		load <= 16'h01F4;
		go(6300);
		pulse_reset();
		chk(32'h804, 32'h0);
		go(150);
		chk(32'h80C, 32'h808);
		residTripEn <= 1'b1;
		go(8);
		chk(32'h404, 32'h404);
		residTripEn <= 1'b0;
		load <= 16'h1388;
		upperLimit <= 16'h12C0;
		go(6300);
		pulse_reset();
		go(200);
		chk(32'h8004, 32'h0);
		go(200);
		chk(32'h8004, 32'h8000);
		load <= 16'h32C8;
		go(50);
		chk(32'h4, 32'h0);
		go(100);
		chk(32'hFFFF0304, 32'h00010304);
		load <= 16'h0C80;
		upperLimit <= 16'h0000;
		lowerLimit <= 16'h0FA0;
		limitTripEn <= 1'b1;
		go(6300);
		pulse_reset();
		go(200);
		chk(32'hE00C, 32'h0008);
		go(200);
		chk(32'hE00C, 32'h2004);
		go(3);
		wrap_up();
	end
endmodule : tb
bind mfs_supervisor mfs_sup_asserts i_mfs_sup_asserts (.clock, .rst, .sensorOverPin,
	.tripResetCmd, .sensorType, .sensorResp, .motorDrive, .tripOut, .sensorOverMsg,
	.wireBreakMsg, .shortCircMsg, .sensorOffMsg, .residWarnMsg, .blockTripMsg,
	.groupFaultMsg, .coolingMsg, .overloadTripCount);
